// >>> common/mmv_pkg.sv
// constants, codes and report type of the mode and violation log block
package mmv_pkg;

    // ==========================================
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] CLEAR_BYTE = 8'hFF;

    // ==========================================
    // register offsets
    localparam logic [7:0] OFS_MODE = 8'h70;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h7E;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h7F;
    localparam logic [7:0] OFS_CODE_HI = 8'h80;
    localparam logic [7:0] OFS_CODE_LO = 8'h81;
    localparam logic [7:0] OFS_FLG_HI = 8'h82;
    localparam logic [7:0] OFS_FLG_LO = 8'h83;
    localparam logic [7:0] OFS_PC_HI = 8'h85;
    localparam logic [7:0] OFS_PC_MID = 8'h86;
    localparam logic [7:0] OFS_PC_LO = 8'h87;

    // ==========================================
    // field positions
    localparam int MODE_BIT = 7;
    localparam int USER_BIT = 7;
    localparam int XMASK_BIT = 6;
    localparam int IMASK_BIT = 4;

    // ==========================================
    // initiator codes
    localparam logic [3:0] INIT_NONE = 4'h0;
    localparam logic [3:0] INIT_CPU = 4'h1;
    localparam logic [3:0] INIT_ADC0 = 4'h3;
    localparam logic [3:0] INIT_ADC1 = 4'h4;
    localparam logic [3:0] INIT_TRIG = 4'h5;

    // target codes
    localparam logic [3:0] TGT_NONE = 4'h0;
    localparam logic [3:0] TGT_REGS = 4'h1;
    localparam logic [3:0] TGT_RAM = 4'h2;
    localparam logic [3:0] TGT_EEPROM = 4'h3;
    localparam logic [3:0] TGT_FLASH = 4'h4;
    localparam logic [3:0] TGT_INFO_ROWS = 4'h5;

    // access type codes
    localparam logic [3:0] ACC_NONE = 4'h0;
    localparam logic [3:0] ACC_OPCODE = 4'h1;
    localparam logic [3:0] ACC_VECTOR = 4'h2;
    localparam logic [3:0] ACC_LOAD = 4'h3;
    localparam logic [3:0] ACC_STORE = 4'h4;

    // violation kind codes
    localparam logic [3:0] KIND_NONE = 4'h0;
    localparam logic [3:0] KIND_ILLEGAL = 4'h1;
    localparam logic [3:0] KIND_ECC = 4'h2;

    // ==========================================
    // interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_LOGGED = 0;
    localparam int IRQ_LOST = 1;
    localparam int IRQ_MODE = 2;

    // ==========================================
    // violation report from the access checker
    typedef struct packed {
        logic [3:0] initiator_field;
        logic [3:0] target_field;
        logic [3:0] access_type_field;
        logic [3:0] violation_kind;
        logic [23:0] program_counter;
        logic user_state;
        logic x_irq_mask;
        logic i_irq_mask;
    } mmv_viol_rpt_t;

endpackage

// >>> logic/mmv_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module mmv_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic [WIDTH-1:0] init_i,
    output logic [WIDTH-1:0] stable_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;

    // ==========================================
    // shift chain; first stage feeds only the second
    always_ff @(posedge sys_clk_i)
    begin
        if (ce_i)
        begin
            meta_ff <= pin_i;
            s2_ff <= meta_ff;
            s3_ff <= s2_ff;
        end
    end

    // ==========================================
    // a bit moves only once stages two and three agree
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            stable_o <= init_i;
        end
        else if (ce_i)
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (s2_ff[i] == s3_ff[i])
                begin
                    stable_o[i] <= s3_ff[i];
                end
            end
        end
    end

endmodule

// >>> logic/mmv_top.sv
// chip-mode register and access-violation log with register port
`timescale 1ns/1ps
// How it works
// - mode pin sampled at reset release into mode bit 7; others read 0
// - mode bit written only for special to normal transition; read outside reset and stop mode
// - high code byte upper nibble holds initiator code
// - high code byte lower nibble holds target code
// - low code byte upper nibble holds access type code
// - low code byte lower nibble holds violation kind code
// - a violation loads a non-zero code into the code pair
// - program counter and flags captured together with the code
// - non-zero code freezes code, counter and flags; first one kept
// - writing 0xFFFF across both code bytes clears and re-arms
// - user state in high flags bit 7; X mask in low flags bit 6, I mask in low flags bit 4
// - flags are read-only and only refreshed by a new logged violation
// - every illegal core access raises a machine exception
// - uncorrectable error on core, converter or trigger access raises one
// - block idles in stop mode; no bus or log activity
module mmv_top #(
    parameter int ADDR_W = mmv_pkg::ADDR_W,
    parameter int DATA_W = mmv_pkg::DATA_W
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic ext_reset_n_i,
    input wire logic mode_select_i,
    input wire logic stop_mode_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rd_data_o,
    input wire logic viol_valid_i,
    input wire mmv_pkg::mmv_viol_rpt_t viol_rpt_i,
    output logic machine_exc_o,
    output logic normal_mode_o,
    output logic log_full_o,
    output logic irq_o
);

    // ==========================================
    // declarations
    logic [1:0] pin_st;
    logic rst_pin_n;
    logic mode_pin;
    logic rst_prev_ff;
    logic rst_release;
    logic in_reset;
    logic active;

    logic mode_bit_ff;
    logic [DATA_W-1:0] code_hi_ff;
    logic [DATA_W-1:0] code_lo_ff;
    logic flg_user_ff;
    logic flg_xmask_ff;
    logic flg_imask_ff;
    logic [23:0] pc_ff;
    logic clr_hi_seen_ff;
    logic clr_lo_seen_ff;
    logic [mmv_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [mmv_pkg::IRQ_W-1:0] irq_mask_ff;

    logic bus_wr;
    logic bus_rd;
    logic wr_hi_clr;
    logic wr_lo_clr;
    logic log_clear;
    logic log_armed;
    logic viol_take;
    logic viol_load;
    logic viol_lost;
    logic mode_wr_ok;
    logic [mmv_pkg::IRQ_W-1:0] irq_set;
    logic [DATA_W-1:0] nxt_rd_data;

    // ==========================================
    // helper functions
    function automatic logic is_real_viol(input mmv_pkg::mmv_viol_rpt_t r);
        return (r.violation_kind == mmv_pkg::KIND_ILLEGAL) ||
               (r.violation_kind == mmv_pkg::KIND_ECC);
    endfunction

    function automatic logic raises_exc(input mmv_pkg::mmv_viol_rpt_t r);
        logic from_core;
        logic from_peri;
        from_core = (r.initiator_field == mmv_pkg::INIT_CPU);
        from_peri = (r.initiator_field == mmv_pkg::INIT_ADC0) ||
                    (r.initiator_field == mmv_pkg::INIT_ADC1) ||
                    (r.initiator_field == mmv_pkg::INIT_TRIG);
        // core: illegal or ecc; converters and trigger unit: ecc only
        return (from_core && is_real_viol(r)) ||
               (from_peri && (r.violation_kind == mmv_pkg::KIND_ECC));
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    // ==========================================
    // pin synchronisers
    mmv_sync3 #(
        .WIDTH(2)
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .pin_i({ext_reset_n_i, mode_select_i}),
        .init_i(2'h0),
        .stable_o(pin_st)
    );

    // both pins pass the same chain, so the mode level is aligned to the edge
    assign rst_pin_n = pin_st[1];
    assign mode_pin = pin_st[0];

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            rst_prev_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            rst_prev_ff <= rst_pin_n;
        end
    end

    assign in_reset = ~rst_pin_n;
    assign rst_release = rst_pin_n & ~rst_prev_ff;
    assign active = ~in_reset & ~stop_mode_i;

    // ==========================================
    // bus decode
    assign bus_wr = wr_i & active;
    assign bus_rd = rd_i & active;
    assign wr_hi_clr = bus_wr && hit(addr_i, mmv_pkg::OFS_CODE_HI) &&
                       (wdata_i == mmv_pkg::CLEAR_BYTE);
    assign wr_lo_clr = bus_wr && hit(addr_i, mmv_pkg::OFS_CODE_LO) &&
                       (wdata_i == mmv_pkg::CLEAR_BYTE);
    // pattern completes when the second half of 0xFFFF lands
    assign log_clear = (wr_hi_clr && clr_lo_seen_ff) ||
                       (wr_lo_clr && clr_hi_seen_ff);
    assign mode_wr_ok = bus_wr && hit(addr_i, mmv_pkg::OFS_MODE) &&
                        !mode_bit_ff && wdata_i[mmv_pkg::MODE_BIT];

    // ==========================================
    // violation intake
    assign log_armed = (code_hi_ff == mmv_pkg::ZERO_BYTE) &&
                       (code_lo_ff == mmv_pkg::ZERO_BYTE);
    assign viol_take = viol_valid_i && active && is_real_viol(viol_rpt_i);
    // a violation in the clearing cycle is kept, not lost
    assign viol_load = viol_take && (log_armed || log_clear);
    assign viol_lost = viol_take && !viol_load;

    // ==========================================
    // clear-pattern tracking
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || in_reset)
        begin
            clr_hi_seen_ff <= 1'b0;
            clr_lo_seen_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            if (log_clear)
            begin
                clr_hi_seen_ff <= 1'b0;
                clr_lo_seen_ff <= 1'b0;
            end
            else if (bus_wr && hit(addr_i, mmv_pkg::OFS_CODE_HI))
            begin
                clr_hi_seen_ff <= wr_hi_clr;
                clr_lo_seen_ff <= 1'b0;
            end
            else if (bus_wr && hit(addr_i, mmv_pkg::OFS_CODE_LO))
            begin
                clr_lo_seen_ff <= wr_lo_clr;
                clr_hi_seen_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // mode register
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            mode_bit_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            if (rst_release)
            begin
                mode_bit_ff <= mode_pin;
            end
            else if (mode_wr_ok)
            begin
                mode_bit_ff <= 1'b1;
            end
        end
    end

    // ==========================================
    // error code pair
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || in_reset)
        begin
            code_hi_ff <= mmv_pkg::ZERO_BYTE;
            code_lo_ff <= mmv_pkg::ZERO_BYTE;
        end
        else if (ce_i)
        begin
            if (viol_load)
            begin
                code_hi_ff <= {viol_rpt_i.initiator_field,
                               viol_rpt_i.target_field};
                code_lo_ff <= {viol_rpt_i.access_type_field,
                               viol_rpt_i.violation_kind};
            end
            else if (log_clear)
            begin
                code_hi_ff <= mmv_pkg::ZERO_BYTE;
                code_lo_ff <= mmv_pkg::ZERO_BYTE;
            end
        end
    end

    // ==========================================
    // captured counter and flags, written only with a new code
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || in_reset)
        begin
            pc_ff <= '0;
            flg_user_ff <= 1'b0;
            flg_xmask_ff <= 1'b0;
            flg_imask_ff <= 1'b0;
        end
        else if (ce_i && viol_load)
        begin
            pc_ff <= viol_rpt_i.program_counter;
            flg_user_ff <= viol_rpt_i.user_state;
            flg_xmask_ff <= viol_rpt_i.x_irq_mask;
            flg_imask_ff <= viol_rpt_i.i_irq_mask;
        end
    end

    // ==========================================
    // machine exception toward the core
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            machine_exc_o <= 1'b0;
        end
        else if (ce_i)
        begin
            machine_exc_o <= viol_valid_i && active &&
                             raises_exc(viol_rpt_i);
        end
    end

    // ==========================================
    // interrupt status and mask
    assign irq_set = {mode_wr_ok, viol_lost, viol_load};

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || in_reset)
        begin
            irq_stat_ff <= '0;
        end
        else if (ce_i)
        begin
            // set wins over the read clear
            if (bus_rd && hit(addr_i, mmv_pkg::OFS_IRQ_STAT))
            begin
                irq_stat_ff <= irq_set;
            end
            else
            begin
                irq_stat_ff <= irq_stat_ff | irq_set;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || in_reset)
        begin
            irq_mask_ff <= '0;
        end
        else if (ce_i && bus_wr && hit(addr_i, mmv_pkg::OFS_IRQ_MASK))
        begin
            irq_mask_ff <= wdata_i[mmv_pkg::IRQ_W-1:0];
        end
    end

    // ==========================================
    // read mux; anything unlisted is reserved and reads zero
    always_comb
    begin
        nxt_rd_data = mmv_pkg::ZERO_BYTE;
        if (bus_rd)
        begin
            case (addr_i)
                ADDR_W'(mmv_pkg::OFS_MODE):
                begin
                    nxt_rd_data[mmv_pkg::MODE_BIT] = mode_bit_ff;
                end
                ADDR_W'(mmv_pkg::OFS_IRQ_STAT):
                begin
                    nxt_rd_data[mmv_pkg::IRQ_W-1:0] = irq_stat_ff;
                end
                ADDR_W'(mmv_pkg::OFS_IRQ_MASK):
                begin
                    nxt_rd_data[mmv_pkg::IRQ_W-1:0] = irq_mask_ff;
                end
                ADDR_W'(mmv_pkg::OFS_CODE_HI):
                begin
                    nxt_rd_data = code_hi_ff;
                end
                ADDR_W'(mmv_pkg::OFS_CODE_LO):
                begin
                    nxt_rd_data = code_lo_ff;
                end
                ADDR_W'(mmv_pkg::OFS_FLG_HI):
                begin
                    nxt_rd_data[mmv_pkg::USER_BIT] = flg_user_ff;
                end
                ADDR_W'(mmv_pkg::OFS_FLG_LO):
                begin
                    nxt_rd_data[mmv_pkg::XMASK_BIT] = flg_xmask_ff;
                    nxt_rd_data[mmv_pkg::IMASK_BIT] = flg_imask_ff;
                end
                ADDR_W'(mmv_pkg::OFS_PC_HI):
                begin
                    nxt_rd_data = pc_ff[23:16];
                end
                ADDR_W'(mmv_pkg::OFS_PC_MID):
                begin
                    nxt_rd_data = pc_ff[15:8];
                end
                ADDR_W'(mmv_pkg::OFS_PC_LO):
                begin
                    nxt_rd_data = pc_ff[7:0];
                end
                default:
                begin
                    nxt_rd_data = mmv_pkg::ZERO_BYTE;
                end
            endcase
        end
    end

    // ==========================================
    // registered outputs
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            rd_data_o <= mmv_pkg::ZERO_BYTE;
        end
        else if (ce_i)
        begin
            rd_data_o <= nxt_rd_data;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            normal_mode_o <= 1'b0;
            log_full_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            // lag of one cycle behind the state they mirror
            normal_mode_o <= mode_bit_ff;
            log_full_o <= !log_armed;
            irq_o <= |(irq_stat_ff & irq_mask_ff);
        end
    end

endmodule

// >>> sim/mmv_core_model.sv
// behavioural requester that issues violation reports
`timescale 1ns/1ps
module mmv_core_model (
    input wire logic sys_clk_i,
    output logic viol_valid_o,
    output mmv_pkg::mmv_viol_rpt_t viol_rpt_o
);
    initial
    begin
        viol_valid_o = 1'b0;
        viol_rpt_o = '0;
    end
    // payload inverted once valid drops, so a stale report never matches
    task automatic send(input logic [15:0] code, input logic [23:0] pc, input logic [2:0] ccr);
        @(posedge sys_clk_i);
        viol_valid_o <= 1'b1;
        viol_rpt_o <= {code, pc, ccr};
        @(posedge sys_clk_i);
        viol_valid_o <= 1'b0;
        viol_rpt_o <= ~{code, pc, ccr};
    endtask
endmodule

// >>> sim/mmv_top_monitor.sv
// port-level assertions for the mode and violation log block
`timescale 1ns/1ps
module mmv_top_monitor #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic ext_reset_n_i,
    input wire logic mode_select_i,
    input wire logic stop_mode_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rd_data_o,
    input wire logic viol_valid_i,
    input wire mmv_pkg::mmv_viol_rpt_t viol_rpt_i,
    input wire logic machine_exc_o,
    input wire logic normal_mode_o,
    input wire logic log_full_o,
    input wire logic irq_o
);
    // ==========================================
    // helpers
    logic [3:0] arm_ff;
    logic armed;
    logic live;
    logic valid_kind;
    logic exc_due;
    logic clr_wr;
    logic rsvd;
    assign armed = (arm_ff == 4'hF);
    assign live = armed && ce_i && !stop_mode_i;
    assign valid_kind = viol_rpt_i.violation_kind inside {4'h1, 4'h2};
    assign exc_due = viol_valid_i && (viol_rpt_i.initiator_field == 4'h1 ? valid_kind
        : (viol_rpt_i.initiator_field inside {4'h3, 4'h4, 4'h5}
        && viol_rpt_i.violation_kind == 4'h2));
    assign clr_wr = wr_i && wdata_i == 8'hFF && addr_i[7:1] == 7'h40;
    assign rsvd = addr_i < 8'h70 || (addr_i > 8'h70 && addr_i < 8'h7E)
        || addr_i == 8'h84 || addr_i > 8'h87;
    // pin synchroniser hides the first cycles after any reset
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || !ext_reset_n_i)
            arm_ff <= 4'h0;
        else if (!armed)
            arm_ff <= arm_ff + 4'h1;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // ==========================================
    // assertions
    a_mode_low_zero: assert property (
        live && rd_i && addr_i == 8'h70 |=> rd_data_o[6:0] == 7'h00)
        else $error("mode register low bits not zero");
    a_mode_write_ok: assert property (
        live && wr_i && addr_i == 8'h70 && wdata_i[7] |-> ##[1:2] normal_mode_o)
        else $error("mode switch not taken");
    a_mode_no_back: assert property (armed |-> !$fell(normal_mode_o))
        else $error("mode returned to special");
    a_code_logged: assert property (
        live && viol_valid_i && valid_kind |-> ##[1:2] log_full_o)
        else $error("violation not logged");
    a_exc_cause: assert property (
        machine_exc_o |-> $past(exc_due && ce_i && !stop_mode_i))
        else $error("exception without cause");
    a_exc_raised: assert property (live && exc_due |=> machine_exc_o)
        else $error("exception missing");
    a_full_clear: assert property (
        armed && $fell(log_full_o) |-> $past(clr_wr, 2) || $past(clr_wr, 3))
        else $error("log emptied without clear pattern");
    a_flags_layout: assert property (
        live && rd_i && addr_i == 8'h83 |=> (rd_data_o & 8'hAF) == 8'h00)
        else $error("flag low byte spare bits set");
    a_reserved_zero: assert property (live && rd_i && rsvd |=> rd_data_o == 8'h00)
        else $error("reserved address read non-zero");
    c_exc: cover property (machine_exc_o);
    c_clear: cover property ($fell(log_full_o));
    c_mode: cover property (live && wr_i && addr_i == 8'h70 && wdata_i[7] && !normal_mode_o);
endmodule
bind mmv_top mmv_top_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_mon (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i), .ext_reset_n_i(ext_reset_n_i),
    .mode_select_i(mode_select_i), .stop_mode_i(stop_mode_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .viol_valid_i(viol_valid_i), .viol_rpt_i(viol_rpt_i), .machine_exc_o(machine_exc_o),
    .normal_mode_o(normal_mode_o), .log_full_o(log_full_o), .irq_o(irq_o));

// >>> sim/tb_top.sv
// self-checking bench for the mode and violation log block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ext_n = 1'b1;
    logic msel = 1'b0;
    logic stop = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic vv;
    mmv_pkg::mmv_viol_rpt_t rpt;
    logic exc, nm, lf, irq;
    int num_errors = 0;
    int num_checks = 0;
    localparam logic [15:0] CODES [6] = '{16'h1111, 16'h3222, 16'h4332,
        16'h5542, 16'h1432, 16'h3241};
    localparam logic [5:0] EXC = 6'b011111;
    localparam logic [7:0] RSVD [6] = '{8'h71, 8'h7D, 8'h84, 8'h88, 8'hFF, 8'h00};
    always #10 clk = ~clk;
    mmv_core_model i_core (.sys_clk_i(clk), .viol_valid_o(vv), .viol_rpt_o(rpt));
    mmv_top i_dut (.sys_clk_i(clk), .srst_i(srst), .ce_i(ce), .ext_reset_n_i(ext_n),
        .mode_select_i(msel), .stop_mode_i(stop), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rd_data_o(rdata), .viol_valid_i(vv), .viol_rpt_i(rpt),
        .machine_exc_o(exc), .normal_mode_o(nm), .log_full_o(lf), .irq_o(irq));
    // ==========================================
    // bus and compare helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk8(n, {7'h00, e}, {7'h00, g});
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk8($sformatf("rd_data_o at %h", a), e, rdata);
    endtask
    task automatic clear_log();
        wr_reg(mmv_pkg::OFS_CODE_HI, 8'hFF);
        wr_reg(mmv_pkg::OFS_CODE_LO, 8'hFF);
    endtask
    task automatic ext_reset(input logic m);
        @(posedge clk);
        ext_n <= 1'b0;
        msel <= m;
        tick(8);
        ext_n <= 1'b1;
        tick(12);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reserved();
        rd_chk(mmv_pkg::OFS_CODE_HI, 8'h00);
        rd_chk(mmv_pkg::OFS_PC_HI, 8'h00);
        wr_reg(8'h84, 8'hFF);
        for (int k = 0; k < 6; k++)
            rd_chk(RSVD[k], 8'h00);
        $display("test reserved done");
    endtask
    task automatic t_mode();
        rd_chk(mmv_pkg::OFS_MODE, 8'h00);
        wr_reg(mmv_pkg::OFS_MODE, 8'h00);
        wr_reg(mmv_pkg::OFS_MODE, 8'h80);
        tick(2);
        #1 chk1("normal_mode_o", 1'b1, nm);
        rd_chk(mmv_pkg::OFS_IRQ_STAT, 8'h04);
        wr_reg(mmv_pkg::OFS_MODE, 8'h00);
        rd_chk(mmv_pkg::OFS_MODE, 8'h80);
        ext_reset(1'b1);
        rd_chk(mmv_pkg::OFS_MODE, 8'h80);
        ext_reset(1'b0);
        rd_chk(mmv_pkg::OFS_MODE, 8'h00);
        $display("test mode done");
    endtask
    task automatic t_log();
        wr_reg(mmv_pkg::OFS_IRQ_MASK, 8'h01);
        rd_chk(mmv_pkg::OFS_IRQ_MASK, 8'h01);
        i_core.send(16'h1241, 24'hA5C3E1, 3'b110);
        #1 chk1("machine_exc_o", 1'b1, exc);
        tick(2);
        #1 chk1("log_full_o", 1'b1, lf);
        chk1("irq_o", 1'b1, irq);
        rd_chk(mmv_pkg::OFS_CODE_HI, 8'h12);
        rd_chk(mmv_pkg::OFS_CODE_LO, 8'h41);
        rd_chk(mmv_pkg::OFS_FLG_HI, 8'h80);
        rd_chk(mmv_pkg::OFS_FLG_LO, 8'h40);
        rd_chk(mmv_pkg::OFS_PC_HI, 8'hA5);
        rd_chk(mmv_pkg::OFS_PC_MID, 8'hC3);
        rd_chk(mmv_pkg::OFS_PC_LO, 8'hE1);
        rd_chk(mmv_pkg::OFS_IRQ_STAT, 8'h01);
        tick(2);
        #1 chk1("irq_o", 1'b0, irq);
        // second report while full: kept out, lost bit masked
        i_core.send(16'h3522, 24'h000001, 3'b001);
        wr_reg(mmv_pkg::OFS_FLG_LO, 8'hFF);
        rd_chk(mmv_pkg::OFS_CODE_HI, 8'h12);
        rd_chk(mmv_pkg::OFS_FLG_LO, 8'h40);
        rd_chk(mmv_pkg::OFS_PC_LO, 8'hE1);
        chk1("irq_o", 1'b0, irq);
        rd_chk(mmv_pkg::OFS_IRQ_STAT, 8'h02);
        wr_reg(mmv_pkg::OFS_CODE_HI, 8'hFF);
        wr_reg(mmv_pkg::OFS_CODE_LO, 8'h00);
        wr_reg(mmv_pkg::OFS_CODE_LO, 8'hFF);
        rd_chk(mmv_pkg::OFS_CODE_HI, 8'h12);
        clear_log();
        rd_chk(mmv_pkg::OFS_CODE_HI, 8'h00);
        rd_chk(mmv_pkg::OFS_CODE_LO, 8'h00);
        rd_chk(mmv_pkg::OFS_FLG_LO, 8'h40);
        #1 chk1("log_full_o", 1'b0, lf);
        $display("test log done");
    endtask
    task automatic t_codes();
        for (int k = 0; k < 6; k++)
        begin
            i_core.send(CODES[k], 24'h010203, 3'b100);
            #1 chk1("machine_exc_o", EXC[k], exc);
            rd_chk(mmv_pkg::OFS_CODE_HI, CODES[k][15:8]);
            rd_chk(mmv_pkg::OFS_CODE_LO, CODES[k][7:0]);
            rd_chk(mmv_pkg::OFS_FLG_LO, 8'h00);
            clear_log();
        end
        $display("test codes done");
    endtask
    task automatic t_stop();
        @(posedge clk);
        stop <= 1'b1;
        i_core.send(16'h1111, 24'h000000, 3'b000);
        #1 chk1("machine_exc_o", 1'b0, exc);
        @(posedge clk);
        stop <= 1'b0;
        i_core.send(16'h1113, 24'h000000, 3'b000);
        #1 chk1("machine_exc_o", 1'b0, exc);
        // clock enable low: a report must neither log nor raise
        @(posedge clk);
        ce <= 1'b0;
        i_core.send(16'h1111, 24'h000000, 3'b000);
        #1 chk1("machine_exc_o", 1'b0, exc);
        @(posedge clk);
        ce <= 1'b1;
        tick(2);
        #1 chk1("log_full_o", 1'b0, lf);
        $display("test stop done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        tick(8);
        srst <= 1'b0;
        tick(8);
        t_reserved();
        t_mode();
        t_log();
        t_codes();
        t_stop();
        wrap_up();
    end
    initial
    begin
        #200000;
        num_errors++;
        wrap_up();
    end
endmodule
